// ---- rtl/fbsl_top.sv ----
// What this block does
// [R1] Load select high shifts the register, low loads it in parallel.
// [R2] Shift moves each stage one place from stage 0 toward stage 3.
// [R3] Load copies the four parallel data inputs into the four stages.
// [R4] Master clear low forces all stages low at once, ignoring everything.
// [R5] An extra output always shows the inverse of the last stage.
// [R6] Shifting with J high and K_n high sets stage 0.
// [R7] Shifting with J low and K_n low clears stage 0.
// [R8] Shifting with J high and K_n low toggles stage 0.
// [R9] Shifting with J low and K_n high keeps stage 0.
// [R10] Transfers happen only on a rising shift clock edge, using prior levels.
// [R11] In load mode the stages act as plain D flip-flops; J, K_n ignored.
// [R12] Board may tie J and K_n together for a plain serial data input.
// [R13] Board shifts toward stage 0 by feeding outputs back one lower.
// [R14] Board may change inputs freely, stable only around each rising edge.
// [R15] After master clear releases, stages stay low until the next edge.
// [R16] Register outputs change only on a clock edge, on master clear or on reset.

// ----------------------------------------------------------------------
// Snapshot buffer: a first-in first-out store with valid and ready.
// ----------------------------------------------------------------------
module fbsl_fifo
#(
	parameter int WIDTH = 4,
	parameter int DEPTH = 8
)
(
	// Clock and reset.
	input  wire logic             sys_clk_i,
	input  wire logic             rst_i,
	// Filling side.
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// Draining side.
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic      [WIDTH-1:0] out_data_o
);

	localparam int ADDR = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	// Pointers carry one extra wrap bit so full and empty differ.
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [ADDR:0]               wr_ptr;
		logic [ADDR:0]               rd_ptr;
	} fbsl_fifo_state_type;

	fbsl_fifo_state_type st;
	fbsl_fifo_state_type next_st;
	logic                full;
	logic                empty;

	// The pointer arithmetic only wraps cleanly on a power of two.
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
	begin : g_depth_check
		$error("fbsl_fifo depth must be a power of two, at least 2");
	end
	if (WIDTH < 1)
	begin : g_width_check
		$error("fbsl_fifo width must be at least 1");
	end

	// Status follows from the pointers alone.
	assign empty       = (st.wr_ptr == st.rd_ptr);
	assign full        = (st.wr_ptr[ADDR-1:0] == st.rd_ptr[ADDR-1:0])
	                     && (st.wr_ptr[ADDR] != st.rd_ptr[ADDR]);
	assign in_ready_o  = !full;
	assign out_valid_o = !empty;
	assign out_data_o  = st.mem[st.rd_ptr[ADDR-1:0]];

	// Write on a taken push, advance the read side on a taken pop.
	always_comb
	begin
		next_st = st;
		if (in_valid_i && !full)
		begin
			next_st.mem[st.wr_ptr[ADDR-1:0]] = in_data_i;
			next_st.wr_ptr = st.wr_ptr + 1'b1;
		end
		if (out_ready_i && !empty)
		begin
			next_st.rd_ptr = st.rd_ptr + 1'b1;
		end
	end

	// State register.
	always_ff @(posedge sys_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			st <= '0;
		end
		else
		begin
			st <= next_st;
		end
	end

endmodule : fbsl_fifo

// ----------------------------------------------------------------------
// Four-stage register with serial pair input and parallel load.
// ----------------------------------------------------------------------
module fbsl_top
(
	// System clock and reset.
	input  wire logic       sys_clk_i,
	input  wire logic       rst_i,
	// Board control pins.
	input  wire logic       master_clear_n_i,
	input  wire logic       shift_clock_i,
	input  wire logic       load_select_n_i,
	// Board data pins.
	input  wire logic       serial_j_i,
	input  wire logic       serial_k_n_i,
	input  wire logic [3:0] load_data_in_i,
	// Register outputs.
	output logic      [3:0] stage_out_o,
	output logic            last_stage_out_o,
	output logic            last_stage_out_inv_o,
	// Snapshot stream of the register value after each shift clock edge, while the buffer has room.
	output logic            snap_in_ready_o,
	output logic            snap_valid_o,
	input  wire logic       snap_ready_i,
	output logic      [3:0] snap_data_o
);

	// The whole state of the register side.
	typedef struct packed {
		fbsl_pkg::fbsl_pins_type sync1;
		fbsl_pkg::fbsl_pins_type sync2;
		logic                    clock_prev;
		logic [3:0]              stages;
		logic                    stage_inv;
		logic                    push;
	} fbsl_state_type;

	localparam fbsl_state_type STATE_RESET = '{
		sync1:      '{shift_clock: fbsl_pkg::CLOCK_RESET, default: '0},
		sync2:      '{shift_clock: fbsl_pkg::CLOCK_RESET, default: '0},
		clock_prev: fbsl_pkg::CLOCK_RESET,
		stages:     fbsl_pkg::STAGES_RESET,
		stage_inv:  fbsl_pkg::STAGE_INV_RESET,
		push:       1'b0
	};

	fbsl_state_type          st;
	fbsl_state_type          next_st;
	fbsl_pkg::fbsl_pins_type pins_now;
	logic                    clear_all;
	logic                    clock_rise;

	// Next content of the stages for one rising edge.
	function automatic logic [3:0] fbsl_step
	(
		input logic [3:0]              stages,
		input fbsl_pkg::fbsl_pins_type pins
	);
		logic [3:0]              result;
		fbsl_pkg::fbsl_mode_type mode;
		result = stages;
		mode   = pins.load_select_n ? fbsl_pkg::FBSL_MODE_SHIFT
		                            : fbsl_pkg::FBSL_MODE_LOAD; // R1
		case (mode)
			fbsl_pkg::FBSL_MODE_SHIFT:
			begin
				// Stage n takes the old stage n-1.
				result[3:1] = stages[2:0]; // R2
				case ({pins.serial_j, pins.serial_k_n})
					fbsl_pkg::JK_SET:
						result[fbsl_pkg::FIRST_STAGE_POS] = 1'b1; // R6
					fbsl_pkg::JK_CLEAR:
						result[fbsl_pkg::FIRST_STAGE_POS] = 1'b0; // R7
					fbsl_pkg::JK_TOGGLE:
						result[fbsl_pkg::FIRST_STAGE_POS] =
							!stages[fbsl_pkg::FIRST_STAGE_POS]; // R8
					fbsl_pkg::JK_HOLD:
						result[fbsl_pkg::FIRST_STAGE_POS] =
							stages[fbsl_pkg::FIRST_STAGE_POS]; // R9
					default:
						result[fbsl_pkg::FIRST_STAGE_POS] =
							stages[fbsl_pkg::FIRST_STAGE_POS];
				endcase
			end
			fbsl_pkg::FBSL_MODE_LOAD:
			begin
				// Serial pair is not looked at in this mode.
				result = pins.load_data_in; // R3 R11
			end
			default:
			begin
				result = stages;
			end
		endcase
		return result;
	endfunction : fbsl_step

	// Master clear acts without the clock, so it joins the async reset.
	assign clear_all = rst_i || !master_clear_n_i; // R4

	// Gather the pins so clock and data cross through the same two stages.
	// Keeping them aligned means the data seen at the detected edge are
	// the levels sampled in the same system clock cycle as the first high clock sample.
	assign pins_now = '{
		shift_clock:   shift_clock_i,
		load_select_n: load_select_n_i,
		serial_j:      serial_j_i,
		serial_k_n:    serial_k_n_i,
		load_data_in:  load_data_in_i
	};

	// Only the second synchroniser stage feeds the edge detector.
	assign clock_rise = st.sync2.shift_clock && !st.clock_prev; // R10

	// Next state: synchronise, detect the rising edge, update the stages.
	always_comb
	begin
		next_st            = st;
		next_st.sync1      = pins_now;
		next_st.sync2      = st.sync1;
		next_st.clock_prev = st.sync2.shift_clock;
		next_st.push       = 1'b0;
		// Between edges the stages hold, whatever the inputs do.
		if (clock_rise) // R16
		begin
			next_st.stages    = fbsl_step(st.stages, st.sync2); // R10
			next_st.stage_inv =
				!next_st.stages[fbsl_pkg::LAST_STAGE_POS]; // R5
			next_st.push      = 1'b1;
		end
	end

	// State register. The clock sync resets high so that a clock pin
	// already high at release does not look like a fresh rising edge.
	always_ff @(posedge sys_clk_i or posedge clear_all)
	begin
		if (clear_all)
		begin
			st <= STATE_RESET; // R4 R15
		end
		else
		begin
			st <= next_st;
		end
	end

	// Register outputs come straight from flip-flops.
	assign stage_out_o          = st.stages;
	assign last_stage_out_o     = st.stages[fbsl_pkg::LAST_STAGE_POS];
	assign last_stage_out_inv_o = st.stage_inv; // R5

	// Each register value after a shift clock edge is offered to the buffer. A full buffer
	// drops the value, since the register itself must never stall.
	fbsl_fifo
	#(
		.WIDTH (fbsl_pkg::STAGE_COUNT),
		.DEPTH (fbsl_pkg::SNAP_DEPTH)
	)
	u_snap_fifo
	(
		.sys_clk_i   (sys_clk_i),
		.rst_i       (rst_i),
		.in_valid_i  (st.push),
		.in_ready_o  (snap_in_ready_o),
		.in_data_i   (st.stages),
		.out_valid_o (snap_valid_o),
		.out_ready_i (snap_ready_i),
		.out_data_o  (snap_data_o)
	);

endmodule : fbsl_top

// ---- rtl/fbsl_pkg.sv ----
// ----------------------------------------------------------------------
// Constants and carriers of the four-stage shift and load register.
// ----------------------------------------------------------------------
package fbsl_pkg;

	// Number of register stages and the positions of the end stages.
	localparam int STAGE_COUNT     = 4;
	localparam int FIRST_STAGE_POS = 0;
	localparam int LAST_STAGE_POS  = 3;

	// Depth of the snapshot buffer that follows the stages.
	localparam int SNAP_DEPTH = 8;

	// Reset values of the stages, the inverted output and the clock sync.
	localparam logic [3:0] STAGES_RESET    = 4'h0;
	localparam logic       STAGE_INV_RESET = 1'h1;
	localparam logic       CLOCK_RESET     = 1'h1;

	// Serial pair encodings as {j, k_n}.
	localparam logic [1:0] JK_CLEAR  = 2'h0;
	localparam logic [1:0] JK_HOLD   = 2'h1;
	localparam logic [1:0] JK_TOGGLE = 2'h2;
	localparam logic [1:0] JK_SET    = 2'h3;

	// Operating mode, taken from the load select pin.
	typedef enum logic {
		FBSL_MODE_LOAD,
		FBSL_MODE_SHIFT
	} fbsl_mode_type;

	// All board inputs except master clear, sampled together on the system clock.
	typedef struct packed {
		logic       shift_clock;
		logic       load_select_n;
		logic       serial_j;
		logic       serial_k_n;
		logic [3:0] load_data_in;
	} fbsl_pins_type;

endpackage : fbsl_pkg

// ---- testbench/fbsl_checker.sv ----
// ----
// Timing checks of the four-stage register.
// ----
module fbsl_checker
(
	// Clock and resets.
	input wire logic       sys_clk_i,
	input wire logic       rst_i,
	input wire logic       master_clear_n_i,
	// Board pins.
	input wire logic       shift_clock_i,
	input wire logic       load_select_n_i,
	input wire logic       serial_j_i,
	input wire logic       serial_k_n_i,
	input wire logic [3:0] load_data_in_i,
	// Register outputs.
	input wire logic [3:0] stage_out_o,
	input wire logic       last_stage_out_o,
	input wire logic       last_stage_out_inv_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	// A rise seen through the pin sync lands three samples later.
	sequence upd;
		master_clear_n_i && $past(master_clear_n_i)
		&& $past(shift_clock_i, 3) && !$past(shift_clock_i, 4);
	endsequence
	sequence shf;
		upd ##0 $past(load_select_n_i, 3);
	endsequence
	// Stage 0 outcome for one serial pair code.
	property p_jk(logic j, logic k, logic v);
		shf ##0 $past(serial_j_i, 3) == j && $past(serial_k_n_i, 3) == k
		|-> stage_out_o[0] == v;
	endproperty
	a_load_copy: assert property (upd ##0 !$past(load_select_n_i, 3)
		|-> stage_out_o == $past(load_data_in_i, 3)) else $error("load bad");
	a_shift_move: assert property (shf
		|-> stage_out_o[3:1] == $past(stage_out_o[2:0])) else $error("shift");
	a_jk_set: assert property (p_jk(1, 1, 1)) else $error("set bad");
	a_jk_clear: assert property (p_jk(0, 0, 0)) else $error("clr bad");
	a_jk_toggle: assert property (p_jk(1, 0,
		!$past(stage_out_o[0]))) else $error("toggle bad");
	a_jk_hold: assert property (p_jk(0, 1,
		$past(stage_out_o[0]))) else $error("hold bad");
	a_last_inverse: assert property (last_stage_out_o == stage_out_o[3]
		&& last_stage_out_inv_o != stage_out_o[3]) else $error("inverse");
	a_clear_forces: assert property (!master_clear_n_i
		|-> stage_out_o == 4'h0) else $error("clear bad");
	a_idle_stable: assert property (master_clear_n_i
		&& $past(master_clear_n_i) && !($past(shift_clock_i, 3)
		&& !$past(shift_clock_i, 4)) |-> $stable(stage_out_o))
		else $error("idle change");
	cover property (shf);
	cover property (upd ##0 !$past(load_select_n_i, 3));
	cover property (!master_clear_n_i);
endmodule : fbsl_checker

bind fbsl_top fbsl_checker chk (.sys_clk_i, .rst_i, .master_clear_n_i,
	.shift_clock_i, .load_select_n_i, .serial_j_i, .serial_k_n_i,
	.load_data_in_i, .stage_out_o, .last_stage_out_o, .last_stage_out_inv_o);

// ---- testbench/fbsl_sink.sv ----
// ----
// Board consumer of the snapshot stream.
// ----
module fbsl_sink
(
	// Flow control from the bench.
	input  wire logic stall_i,
	// Stream handshake.
	output logic      ready_o
);
	// A stalled consumer lets the buffer fill up to its refusal.
	assign ready_o = !stall_i;
endmodule : fbsl_sink

// ---- testbench/tb_top.sv ----
// ----
// Bench of the four-stage register.
// ----
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// Pins are {load_select_n, j, k_n, load data}.
	logic        sys_clk_i = 1'h0;
	logic        rst_i = 1'h1;
	logic        clr_n = 1'h1;
	logic        sclk = 1'h0;
	logic [6:0]  pins = 7'h00;
	logic        stall = 1'h1;
	logic        rdy, last, inv, in_rdy, vld;
	logic [3:0]  stage, sdata;
	int          err_count = 0;
	int          comparisons = 0;
	int          n;
	// Rows are {pins, expected stages}.
	logic [10:0] rows [8] = '{11'h3AA, 11'h705, 11'h40A, 11'h605,
		11'h50B, 11'h507, 11'h2FF, 11'h40E};
	always #5 sys_clk_i = ~sys_clk_i;
	fbsl_top dut (.sys_clk_i, .rst_i, .master_clear_n_i(clr_n),
		.shift_clock_i(sclk), .load_select_n_i(pins[6]),
		.serial_j_i(pins[5]), .serial_k_n_i(pins[4]),
		.load_data_in_i(pins[3:0]), .stage_out_o(stage),
		.last_stage_out_o(last), .last_stage_out_inv_o(inv),
		.snap_in_ready_o(in_rdy), .snap_valid_o(vld),
		.snap_ready_i(rdy), .snap_data_o(sdata));
	fbsl_sink board (.stall_i(stall), .ready_o(rdy));
	task check(input logic [3:0] seen, input logic [3:0] exp, string what);
		comparisons++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	// Clock pulses last three edges each way, longer than the sync needs.
	task pulse(input logic [6:0] p);
		@(posedge sys_clk_i) pins <= p;
		@(posedge sys_clk_i) sclk <= 1'h1;
		repeat (3) @(posedge sys_clk_i);
		sclk <= 1'h0;
		repeat (3) @(posedge sys_clk_i);
	endtask : pulse
	task conclude();
		if (err_count == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : conclude
	// Main sequence: table rows fill the stalled buffer, then hand cases.
	initial
	begin
		repeat (2) @(posedge sys_clk_i);
		rst_i <= 1'h0;
		foreach (rows[i])
		begin
			pulse(rows[i][10:4]);
			check(stage, rows[i][3:0], "stages");
			check({3'h0, inv}, {3'h0, ~rows[i][3]}, "inv");
			check({3'h0, last}, {3'h0, rows[i][3]}, "last");
		end
		check({3'h0, in_rdy}, 4'h0, "full");
		pulse(7'h40);
		check(stage, 4'hC, "shift full");
		stall <= 1'h0;
		n = 0;
		repeat (40)
		begin
			@(posedge sys_clk_i);
			if (vld && rdy && n < 8)
			begin
				check(sdata, rows[n][3:0], "snapshot");
				n++;
			end
		end
		check(4'(n), 4'h8, "count");
		clr_n <= 1'h0;
		repeat (2) @(posedge sys_clk_i);
		check(stage, 4'h0, "clear");
		check({3'h0, inv}, 4'h1, "clear inv");
		clr_n <= 1'h1;
		pins <= 7'h05;
		repeat (6) @(posedge sys_clk_i);
		check(stage, 4'h0, "idle");
		pulse(7'h05);
		check(stage, 4'h5, "reload");
		// The board feeds each output back one place lower to shift down.
		pulse({3'h0, 1'h0, stage[3:1]});
		check(stage, 4'h2, "shift down");
		// One common serial line drives both J and K_n.
		pulse({1'h1, 2'h3, 4'h0});
		check(stage, 4'h5, "serial one");
		pulse({1'h1, 2'h0, 4'h0});
		check(stage, 4'hA, "serial zero");
		// Inputs wander between edges and change again once an edge is
		// taken; only the levels held around the rise may matter.
		pins <= 7'h7F;
		@(posedge sys_clk_i) pins <= 7'h00;
		@(posedge sys_clk_i) pins <= 7'h0C;
		repeat (3) @(posedge sys_clk_i);
		check(stage, 4'hA, "wander");
		sclk <= 1'h1;
		repeat (2) @(posedge sys_clk_i);
		pins <= 7'h73;
		@(posedge sys_clk_i) sclk <= 1'h0;
		repeat (3) @(posedge sys_clk_i);
		check(stage, 4'hC, "late change");
		conclude();
	end
	// The whole run needs under two microseconds; this cuts off a hang.
	initial
	begin
		#100us;
		err_count++;
		conclude();
	end
endmodule : tb_top
